//--- hw/rpg_defines.svh
// register offsets, field positions, reset values and timing counts for the port guard
// assumes a 40 mhz system clock and 32-bit aligned register words
`ifndef RPG_DEFINES_SVH
`define RPG_DEFINES_SVH

// register byte offsets
`define RPG_OFS_CTRL       12'h000
`define RPG_OFS_TIMEOUT    12'h004
`define RPG_OFS_MAXLEN     12'h008
`define RPG_OFS_STATUS     12'h00C
`define RPG_OFS_PNP_ID     12'h010
`define RPG_OFS_SERIAL     12'h014

// control bits
`define RPG_CTRL_OVR_EN    0
`define RPG_CTRL_UND_EN    1
`define RPG_CTRL_AUTODIS   2
`define RPG_CTRL_KEEP_LOW  3
`define RPG_CTRL_LINK_EN   4
`define RPG_CTRL_W         5

// status bits, write one to clear
`define RPG_ST_OVR         0
`define RPG_ST_UND         1
`define RPG_ST_TRUNC       2
`define RPG_ST_DISC        3
`define RPG_ST_W           4

// reset values
`define RPG_CTRL_RST       5'h10
`define RPG_TIMEOUT_RST    16'h0001
`define RPG_MAXLEN_RST     32'h0000_0000
`define RPG_VENDOR_RST     16'h0001
`define RPG_PRODUCT_RST    16'h0001
`define RPG_SERIAL_RST     28'h000_0000

// timeout limits in 100 us steps
`define RPG_TIMEOUT_MAX    17'h0_FFFF
`define RPG_TIMEOUT_W      16

// timing
`define RPG_TICK_US        100
`define RPG_CLK_MHZ        40
`define RPG_TICK_CYCLES    (`RPG_TICK_US * `RPG_CLK_MHZ)

// character layout: bit 8 marks an end marker, bit 0 of an end marker set means error end
`define RPG_CHAR_W         9
`define RPG_CHAR_CTRL      8

`endif

//--- hw/rpg_guard.sv
// port guard: link receive sampling, 4-word fifo, length limiter, transfer supervision,
// auto-disconnect and plug-and-play identity, with an axi4-lite register slave
// assumes one system clock aclk, synchronous active-low aresetn, link clock sampled as data
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`include "rpg_defines.svh"

module rpg_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // refused at elaboration, the pointers wrap only on a power of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
    $error("rpg_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge aclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= rd_q + AW'(1);
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + (AW+1)'(1);
      end else if (pop && !push) begin
        cnt_q <= cnt_q - (AW+1)'(1);
      end
    end
  end
endmodule

// How it works
// - with overrun supervision on, a flag rises when buffered data waits unaccepted too long.
// - with underrun supervision on, a flag rises when the output waits mid-packet for data too long.
// - the timeout is written in 100 us steps from 1 to 65535, and larger or zero writes are refused.
// - overrun and underrun enables are separate bits that share the single timeout value.
// - with auto-disconnect on, the link enable drops after the timeout passes with no traffic.
// - auto-disconnect can only be enabled when the port is a link port, else the write is refused.
// - the port holds its own maximum length, applied to the packets entering it.
// - a packet growing past the maximum is cut and closed with an error end marker.
// - a maximum length of zero turns length checking off.
// - vendor, product and serial identity are held in writable registers and driven out.
// - serial bits 3:0 reset to the instance select pins and can be kept on later writes.
module rpg_guard
  import rpg_pkg::*;
#(
  parameter int          LEN_W      = 32,
  parameter int          FIFO_DEPTH = 4,
  parameter bit          IS_LINK    = 1'b1,
  parameter logic [27:0] SERIAL_RST = `RPG_SERIAL_RST
) (
  // clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // axi4-lite write address
  input  wire logic [11:0]            s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // axi4-lite read
  input  wire logic [11:0]            s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // link receive side
  input  wire logic                   link_clk,
  input  wire logic                   link_valid,
  input  wire rpg_pkg::rpg_char_t     link_data,
  output logic                        link_ready,
  output logic                        link_enable,
  // switch fabric side
  output logic                        out_valid,
  input  wire logic                   out_ready,
  output rpg_pkg::rpg_char_t          out_data,
  // identity
  input  wire logic [7:0]             node_instance_select,
  output logic [15:0]                 pnp_vendor_id,
  output logic [15:0]                 pnp_product_id,
  output logic [31:0]                 pnp_serial
);
  import rpg_pkg::*;

  localparam int TW = `RPG_TIMEOUT_W;
  localparam logic [12:0] TICK_LAST = 13'(`RPG_TICK_CYCLES - 1);

  if (LEN_W < 1 || LEN_W > 32) begin : g_len_check
    $error("rpg_guard LEN_W must lie in 1..32");
  end

  // ---------------- registers ----------------
  logic [`RPG_CTRL_W-1:0] ctrl_q;
  logic [TW-1:0]          timeout_q;
  logic [LEN_W-1:0]       maxlen_q;
  logic [`RPG_ST_W-1:0]   status_q;
  logic [3:0]             inst_q;
  logic                   in_reset_q;

  // axi handshake state
  logic        aw_held_q;
  logic        w_held_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        do_write;
  logic        wr_err;
  logic [31:0] wmask;

  // datapath events feeding the status register
  logic ovr_fire;
  logic und_fire;
  logic idle_fire;
  logic trunc_ev;

  assign do_write = aw_held_q & w_held_q & ~s_axi_bvalid;
  assign wmask    = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  // write is refused for bad timeouts, illegal auto-disconnect and unmapped offsets
  always_comb begin
    wr_err = 1'b0;
    unique case (awaddr_q)
      `RPG_OFS_CTRL: begin
        wr_err = !IS_LINK && wstrb_q[0] && wdata_q[`RPG_CTRL_AUTODIS];
      end
      `RPG_OFS_TIMEOUT: begin
        wr_err = (wdata_q[16:0] == 17'h0_0000) || (wdata_q > 32'(`RPG_TIMEOUT_MAX));
      end
      `RPG_OFS_MAXLEN, `RPG_OFS_STATUS, `RPG_OFS_PNP_ID, `RPG_OFS_SERIAL: begin
        wr_err = 1'b0;
      end
      default: begin
        wr_err = 1'b1;
      end
    endcase
  end

  // write address and data are taken in either order, response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RPG_RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_held_q & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_held_q & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= {s_axi_awaddr[11:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_err ? RPG_RESP_SLVERR : RPG_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_held_q     <= 1'b0;
        w_held_q      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // instance select is caught while reset is held
  always_ff @(posedge aclk) begin
    in_reset_q <= ~aresetn;
    if (!aresetn) begin
      inst_q <= node_instance_select[3:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q      <= `RPG_CTRL_RST;
      timeout_q   <= `RPG_TIMEOUT_RST;
      maxlen_q    <= LEN_W'(`RPG_MAXLEN_RST);
      link_enable <= 1'b1;
    end else begin
      if (do_write && !wr_err && awaddr_q == `RPG_OFS_CTRL && wstrb_q[0]) begin
        ctrl_q <= wdata_q[`RPG_CTRL_W-1:0];
      end else if (idle_fire) begin
        ctrl_q[`RPG_CTRL_LINK_EN] <= 1'b0;
      end
      link_enable <= ctrl_q[`RPG_CTRL_LINK_EN] & ~idle_fire;
      if (do_write && !wr_err && awaddr_q == `RPG_OFS_TIMEOUT) begin
        timeout_q <= wdata_q[TW-1:0];
      end
      if (do_write && awaddr_q == `RPG_OFS_MAXLEN) begin
        maxlen_q <= (maxlen_q & ~wmask[LEN_W-1:0]) | (wdata_q[LEN_W-1:0] & wmask[LEN_W-1:0]);
      end
    end
  end

  // sticky status, a new event wins over the clearing write
  logic [`RPG_ST_W-1:0] st_set;
  logic [`RPG_ST_W-1:0] st_clr;

  always_comb begin
    st_set = '0;
    st_set[`RPG_ST_OVR]   = ovr_fire;
    st_set[`RPG_ST_UND]   = und_fire;
    st_set[`RPG_ST_TRUNC] = trunc_ev;
    st_set[`RPG_ST_DISC]  = idle_fire;
    st_clr = '0;
    if (do_write && awaddr_q == `RPG_OFS_STATUS && wstrb_q[0]) begin
      st_clr = wdata_q[`RPG_ST_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~st_clr) | st_set;
    end
  end

  // plug-and-play identity
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pnp_vendor_id  <= `RPG_VENDOR_RST;
      pnp_product_id <= `RPG_PRODUCT_RST;
      pnp_serial     <= {SERIAL_RST, 4'h0};
    end else if (in_reset_q) begin
      pnp_serial[3:0] <= inst_q;
    end else if (do_write && awaddr_q == `RPG_OFS_PNP_ID) begin
      pnp_vendor_id  <= wdata_q[31:16];
      pnp_product_id <= wdata_q[15:0];
    end else if (do_write && awaddr_q == `RPG_OFS_SERIAL) begin
      pnp_serial[31:4] <= wdata_q[31:4];
      // kept bits go back to the value caught in reset, not to the last written one
      pnp_serial[3:0]  <= ctrl_q[`RPG_CTRL_KEEP_LOW] ? inst_q : wdata_q[3:0];
    end
  end

  // read channel answers one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RPG_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RPG_RESP_OKAY;
        unique case ({s_axi_araddr[11:2], 2'h0})
          `RPG_OFS_CTRL:    s_axi_rdata <= 32'(ctrl_q);
          `RPG_OFS_TIMEOUT: s_axi_rdata <= 32'(timeout_q);
          `RPG_OFS_MAXLEN:  s_axi_rdata <= 32'(maxlen_q);
          `RPG_OFS_STATUS:  s_axi_rdata <= 32'(status_q);
          `RPG_OFS_PNP_ID:  s_axi_rdata <= {pnp_vendor_id, pnp_product_id};
          `RPG_OFS_SERIAL:  s_axi_rdata <= pnp_serial;
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RPG_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ---------------- link sampling ----------------
  logic [2:0]     lclk_s_q;
  logic [2:0]     lval_s_q;
  rpg_char_t      ldat_s1_q;
  rpg_char_t      ldat_s2_q;
  rpg_char_t      ldat_s3_q;
  logic           lclk_lvl_q;
  logic           lclk_rise;
  logic           fifo_in_ready;
  logic           fifo_push;

  always_ff @(posedge aclk) begin
    lclk_s_q  <= {lclk_s_q[1:0], link_clk};
    lval_s_q  <= {lval_s_q[1:0], link_valid};
    ldat_s1_q <= link_data;
    ldat_s2_q <= ldat_s1_q;
    ldat_s3_q <= ldat_s2_q;
  end

  // the clock level changes only once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lclk_lvl_q <= 1'b0;
      link_ready <= 1'b0;
    end else begin
      if (lclk_s_q[1] == lclk_s_q[2]) begin
        lclk_lvl_q <= lclk_s_q[2];
      end
      link_ready <= fifo_in_ready;
    end
  end

  assign lclk_rise = lclk_s_q[1] & lclk_s_q[2] & ~lclk_lvl_q;
  assign fifo_push = lclk_rise & lval_s_q[2] & link_ready & ctrl_q[`RPG_CTRL_LINK_EN];

  rpg_char_t fifo_data;
  logic      fifo_valid;
  logic      fifo_pop_rdy;

  rpg_fifo #(
    .WIDTH (`RPG_CHAR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (ldat_s3_q),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop_rdy),
    .out_data  (fifo_data)
  );

  // ---------------- length limiter ----------------
  logic [LEN_W-1:0] len_q;
  logic             drop_q;
  logic             in_pkt_q;
  logic             ostage_free;
  logic             cut;
  logic             emit;
  logic             out_fire;

  assign ostage_free  = ~out_valid | out_ready;
  assign cut          = fifo_valid & ~drop_q & ~fifo_data[`RPG_CHAR_CTRL] &
                        (maxlen_q != '0) & (len_q == maxlen_q);
  assign emit         = fifo_valid & ~drop_q & ostage_free;
  assign fifo_pop_rdy = drop_q | (ostage_free & ~cut);
  assign out_fire     = out_valid & out_ready;
  assign trunc_ev     = emit & cut;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid <= 1'b0;
      out_data  <= '0;
      len_q     <= '0;
      drop_q    <= 1'b0;
      in_pkt_q  <= 1'b0;
    end else begin
      if (out_fire) begin
        out_valid <= 1'b0;
      end
      if (drop_q) begin
        if (fifo_valid && fifo_data[`RPG_CHAR_CTRL]) begin
          drop_q <= 1'b0; // rest of a cut packet is discarded up to its end marker
        end
      end else if (emit && cut) begin
        out_valid <= 1'b1;
        out_data  <= 9'h101;
        drop_q    <= 1'b1;
        len_q     <= '0;
        in_pkt_q  <= 1'b0;
      end else if (emit) begin
        out_valid <= 1'b1;
        out_data  <= fifo_data;
        if (fifo_data[`RPG_CHAR_CTRL]) begin
          len_q    <= '0;
          in_pkt_q <= 1'b0;
        end else begin
          len_q    <= len_q + LEN_W'(1);
          in_pkt_q <= 1'b1;
        end
      end
    end
  end

  // ---------------- supervision ----------------
  logic [12:0]  tick_cnt_q;
  logic         tick;
  logic [TW:0]  ovr_cnt_q;
  logic [TW:0]  und_cnt_q;
  logic [TW:0]  idle_cnt_q;
  logic         ovr_cond;
  logic         und_cond;
  logic         idle_cond;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 13'(1);
    end
  end

  assign tick      = (tick_cnt_q == TICK_LAST);
  assign ovr_cond  = ctrl_q[`RPG_CTRL_OVR_EN] & fifo_valid & out_valid & ~out_ready;
  assign und_cond  = ctrl_q[`RPG_CTRL_UND_EN] & in_pkt_q & ~fifo_valid & ~out_valid &
                     out_ready;
  assign idle_cond = ctrl_q[`RPG_CTRL_AUTODIS] & ctrl_q[`RPG_CTRL_LINK_EN] &
                     ~fifo_push & ~out_fire;
  assign ovr_fire  = ovr_cond & tick & (ovr_cnt_q == {1'b0, timeout_q} - (TW+1)'(1));
  assign und_fire  = und_cond & tick & (und_cnt_q == {1'b0, timeout_q} - (TW+1)'(1));
  assign idle_fire = idle_cond & tick & (idle_cnt_q == {1'b0, timeout_q} - (TW+1)'(1));

  // each counter restarts when its data movement progresses and stops once it has fired
  always_ff @(posedge aclk) begin
    if (!aresetn || !ovr_cond) begin
      ovr_cnt_q <= '0;
    end else if (tick && ovr_cnt_q != {1'b0, timeout_q}) begin
      ovr_cnt_q <= ovr_cnt_q + (TW+1)'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !und_cond) begin
      und_cnt_q <= '0;
    end else if (tick && und_cnt_q != {1'b0, timeout_q}) begin
      und_cnt_q <= und_cnt_q + (TW+1)'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !idle_cond) begin
      idle_cnt_q <= '0;
    end else if (tick && idle_cnt_q != {1'b0, timeout_q}) begin
      idle_cnt_q <= idle_cnt_q + (TW+1)'(1);
    end
  end
endmodule

//--- hw/rpg_pkg.sv
// types shared by the port guard design
// assumes rpg_defines.svh for all numeric constants
package rpg_pkg;
  typedef logic [8:0] rpg_char_t;
  typedef enum logic [1:0] {
    RPG_RESP_OKAY   = 2'h0,
    RPG_RESP_SLVERR = 2'h2
  } rpg_resp_e;
endpackage

//--- sim/rpg_guard_chk.sv
// port assertions for rpg_guard
// assumes a bind from the bench top and one aclk domain
`timescale 1ns/100ps
`include "rpg_defines.svh"
module rpg_guard_chk (
  // clock and reset
  input wire logic               aclk,
  input wire logic               aresetn,
  // register bus
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  // stream and link
  input wire logic               out_valid,
  input wire logic               out_ready,
  input wire rpg_pkg::rpg_char_t out_data,
  input wire logic               link_enable,
  // identity
  input wire logic [7:0]         node_instance_select,
  input wire logic [15:0]        pnp_vendor_id,
  input wire logic [15:0]        pnp_product_id,
  input wire logic [31:0]        pnp_serial
);
  import rpg_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid && !s_axi_awready && !s_axi_wready) else $error("write not answered");
  chk_resp_ready: assert property (
    s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready && !s_axi_bvalid)
    else $error("write channel not reopened");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready) else $error("read late");
  chk_read_reopen: assert property (
    s_axi_rvalid && s_axi_rready |=> s_axi_arready && !s_axi_rvalid) else $error("read stuck");
  chk_out_hold: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data)) else $error("stream dropped");
  chk_disc_idle: assert property (
    $fell(link_enable) |-> !$past(out_valid && out_ready)) else $error("disconnect while busy");
  chk_reset_ids: assert property (
    $rose(aresetn) |-> pnp_vendor_id == `RPG_VENDOR_RST && pnp_product_id == `RPG_PRODUCT_RST)
    else $error("identity reset wrong");
  chk_serial_low: assert property (
    $rose(aresetn) |=> pnp_serial[3:0] == $past(node_instance_select[3:0], 2))
    else $error("serial low bits wrong");
endmodule

//--- sim/rpg_link_src.sv
// link sender model: one frame per character, link clock still between frames
// assumes the guard takes a char on a link clock rise while link_ready is high
`timescale 1ns/100ps
module rpg_link_src (
  // sampling reference
  input  wire logic          aclk,
  input  wire logic          link_ready,
  // link wires
  output logic               link_clk,
  output logic               link_valid,
  output rpg_pkg::rpg_char_t link_data
);
  import rpg_pkg::*;
  initial begin
    link_clk   = 1'b0;
    link_valid = 1'b0;
    link_data  = 9'h0AA;
  end
  task automatic send(input rpg_char_t c);
    link_valid = 1'b1;
    link_data  = c;
    #100;
    // hold the char while the guard has no room
    while (link_ready !== 1'b1) @(posedge aclk);
    #5;
    link_clk = 1'b1;
    #100;
    link_clk   = 1'b0;
    link_valid = 1'b0;
    // released wire no longer shows the last char
    link_data  = ~c;
  endtask
endmodule

//--- sim/test_rpg_guard.sv
// bench for rpg_guard: register rows, timeouts, disconnect, truncation
// assumes rpg_link_src on the link and rpg_guard_chk bound to the guard
`timescale 1ns/100ps
`include "rpg_defines.svh"
module test_rpg_guard;
  import rpg_pkg::*;
  typedef struct {logic wr; logic [11:0] a; logic [31:0] d; logic [1:0] r;} rpg_row_s;
  logic        aclk, aresetn, link_clk, link_valid, link_ready, link_enable, out_valid;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, out_ready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, pnp_serial, rd;
  logic [15:0] pnp_vendor_id, pnp_product_id;
  logic [7:0]  node_instance_select;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  rpg_char_t   link_data, out_data;
  rpg_char_t   rx_q[$];
  rpg_char_t   pkt[$] = '{9'h011, 9'h022, 9'h033, 9'h044, 9'h055, 9'h100};
  rpg_char_t   cut[$] = '{9'h011, 9'h022, 9'h033, 9'h101};
  int          checks, n_mismatch;
  rpg_row_s    rows[25] = '{
    '{0, `RPG_OFS_CTRL, 32'h0000_0010, 2'h0}, '{0, `RPG_OFS_TIMEOUT, 32'h0000_0001, 2'h0},
    '{0, `RPG_OFS_MAXLEN, 32'h0000_0000, 2'h0}, '{0, `RPG_OFS_STATUS, 32'h0000_0000, 2'h0},
    '{0, `RPG_OFS_PNP_ID, 32'h0001_0001, 2'h0}, '{0, `RPG_OFS_SERIAL, 32'h0000_0005, 2'h0},
    '{0, 12'h018, 32'h0000_0000, 2'h2}, '{1, 12'h020, 32'h0000_0000, 2'h2},
    '{1, `RPG_OFS_TIMEOUT, 32'h0000_0000, 2'h2}, '{1, `RPG_OFS_TIMEOUT, 32'h0001_0000, 2'h2},
    '{0, `RPG_OFS_TIMEOUT, 32'h0000_0001, 2'h0}, '{1, `RPG_OFS_TIMEOUT, 32'h0000_FFFF, 2'h0},
    '{0, `RPG_OFS_TIMEOUT, 32'h0000_FFFF, 2'h0}, '{1, `RPG_OFS_PNP_ID, 32'h1234_5678, 2'h0},
    '{0, `RPG_OFS_PNP_ID, 32'h1234_5678, 2'h0}, '{1, `RPG_OFS_CTRL, 32'h0000_0018, 2'h0},
    '{1, `RPG_OFS_SERIAL, 32'hABCD_EF9A, 2'h0}, '{0, `RPG_OFS_SERIAL, 32'hABCD_EF95, 2'h0},
    '{1, `RPG_OFS_CTRL, 32'h0000_0010, 2'h0}, '{1, `RPG_OFS_SERIAL, 32'h1111_111A, 2'h0},
    '{0, `RPG_OFS_SERIAL, 32'h1111_111A, 2'h0}, '{1, `RPG_OFS_TIMEOUT, 32'h0000_0002, 2'h0},
    '{1, `RPG_OFS_CTRL, 32'h0000_0018, 2'h0}, '{1, `RPG_OFS_SERIAL, 32'h2222_2223, 2'h0},
    '{0, `RPG_OFS_SERIAL, 32'h2222_2225, 2'h0}};

  rpg_guard #(.IS_LINK(1'b1)) u_rpg_guard (.*);
  rpg_link_src u_rpg_link_src (.aclk(aclk), .link_ready(link_ready), .link_clk(link_clk),
                               .link_valid(link_valid), .link_data(link_data));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) if (out_valid === 1'b1 && out_ready === 1'b1) rx_q.push_back(out_data);

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_char(input rpg_char_t got, input rpg_char_t exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic send_pkt(input rpg_char_t p[$]);
    foreach (p[i]) u_rpg_link_src.send(p[i]);
  endtask
  task automatic check_rx(input rpg_char_t e[$]);
    cmp_word(rx_q.size(), e.size());
    foreach (e[i]) cmp_char(rx_q[i], e[i]);
    rx_q.delete();
  endtask
  task automatic final_report;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #2_000_000;
    n_mismatch++;
    final_report();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    out_ready = 1'b1;
    node_instance_select = 8'hA5;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) axi_wr(rows[i].a, rows[i].d, rsp);
      else begin
        axi_rd(rows[i].a, rd, rsp);
        cmp_word(rd, rows[i].d);
      end
      cmp_word({30'h0, rsp}, {30'h0, rows[i].r});
    end
    cmp_word({pnp_vendor_id, pnp_product_id}, 32'h1234_5678);
    cmp_word(pnp_serial, 32'h2222_2225);
    // stalled fabric, then starved fabric, on one packet
    axi_wr(`RPG_OFS_CTRL, 32'h0000_0013, rsp);
    out_ready <= 1'b0;
    fork
      send_pkt(pkt[0:4]);
    join_none
    repeat (3000) @(posedge aclk);
    axi_rd(`RPG_OFS_STATUS, rd, rsp);
    cmp_word(rd, 32'h0000_0000);
    repeat (6000) @(posedge aclk);
    cmp_word({31'h0, link_ready}, 32'h0000_0000);
    axi_rd(`RPG_OFS_STATUS, rd, rsp);
    cmp_word(rd, 32'h0000_0001);
    out_ready <= 1'b1;
    wait fork;
    repeat (9000) @(posedge aclk);
    axi_rd(`RPG_OFS_STATUS, rd, rsp);
    cmp_word(rd, 32'h0000_0003);
    send_pkt(pkt[5:5]);
    repeat (20) @(posedge aclk);
    check_rx(pkt);
    axi_wr(`RPG_OFS_STATUS, 32'h0000_000F, rsp);
    axi_rd(`RPG_OFS_STATUS, rd, rsp);
    cmp_word(rd, 32'h0000_0000);
    // idle link with auto-disconnect on
    axi_wr(`RPG_OFS_CTRL, 32'h0000_0014, rsp);
    cmp_word({30'h0, rsp}, 32'h0000_0000);
    repeat (9000) @(posedge aclk);
    cmp_word({31'h0, link_enable}, 32'h0000_0000);
    axi_rd(`RPG_OFS_STATUS, rd, rsp);
    cmp_word(rd, 32'h0000_0008);
    axi_wr(`RPG_OFS_CTRL, 32'h0000_0010, rsp);
    repeat (3) @(posedge aclk);
    cmp_word({31'h0, link_enable}, 32'h0000_0001);
    // length limit of three, then limit off
    axi_wr(`RPG_OFS_MAXLEN, 32'h0000_0003, rsp);
    send_pkt(pkt);
    repeat (20) @(posedge aclk);
    check_rx(cut);
    axi_rd(`RPG_OFS_STATUS, rd, rsp);
    cmp_word(rd, 32'h0000_000C);
    axi_wr(`RPG_OFS_MAXLEN, 32'h0000_0000, rsp);
    send_pkt(pkt);
    repeat (20) @(posedge aclk);
    check_rx(pkt);
    final_report();
  end
endmodule

bind rpg_guard rpg_guard_chk u_rpg_guard_chk (.*);
